// File: logic/tsd_pkg.sv
package tsd_pkg;
  // byte-stream framing
  localparam int TSD_BYTES_PER_WORD = 3;
  localparam int TSD_WORD_W = 24;
  // prescaler moduli
  localparam int TSD_DOWN_PRESCALE = 64;
  localparam int TSD_UP_PRESCALE = 16;
  // main divider fields
  localparam int TSD_A_LSB = 2;
  localparam int TSD_A_W = 7;
  localparam int TSD_B_LSB = 9;
  localparam int TSD_B_W = 11;
  // reference divider fields
  localparam int TSD_DOWN_R_LSB = 2;
  localparam int TSD_DOWN_R_W = 12;
  localparam int TSD_UP_R_LSB = 2;
  localparam int TSD_UP_R_W = 10;
  // control register I fields
  localparam int TSD_WAKE_BIT = 19;
  localparam int TSD_UP_CP_LSB = 8;
  localparam int TSD_DOWN_CP_LSB = 12;
  localparam int TSD_CP_W = 3;
  // address patterns: byte-0 high nibble plus low two bits
  localparam logic [3:0] TSD_HI_DIV = 4'h0;
  localparam logic [3:0] TSD_HI_REF = 4'h1;
  localparam logic [3:0] TSD_HI_CTL1 = 4'h4;
  localparam logic [3:0] TSD_HI_CTL2 = 4'h5;
  localparam logic [3:0] TSD_HI_CTL3 = 4'h6;
  localparam logic [1:0] TSD_LO_DOWN_MAIN = 2'h1;
  localparam logic [1:0] TSD_LO_DOWN_REF = 2'h0;
  localparam logic [1:0] TSD_LO_UP_MAIN = 2'h3;
  localparam logic [1:0] TSD_LO_UP_REF = 2'h2;
  localparam logic [1:0] TSD_LO_CTL = 2'h1;
  localparam logic [1:0] TSD_LO_CTL3 = 2'h3;
  // reset values
  localparam logic TSD_WAKE_RST = 1'b0;
  localparam logic [2:0] TSD_CP_RST = 3'h1;
  localparam logic [10:0] TSD_B_RST = 11'h002;
  localparam logic [6:0] TSD_A_RST = 7'h00;
  localparam logic [11:0] TSD_R_RST = 12'h002;

  typedef struct packed {
    logic [10:0] b_count;
    logic [6:0] a_count;
    logic [11:0] r_count;
  } tsd_synth_t;

  typedef struct packed {
    logic wake;
    logic [2:0] up_pump_current;
    logic [2:0] down_pump_current;
  } tsd_ctrl_t;

  typedef struct packed {
    logic ctl2_seen;
    logic ctl3_seen;
  } tsd_fixed_t;
endpackage

// File: logic/tsd_regs.sv
`timescale 1ns/1ps
module tsd_regs
  import tsd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic frame_start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output tsd_synth_t down_synth,
  output tsd_synth_t up_synth,
  output logic [16:0] down_synth_n,
  output logic [14:0] up_synth_n,
  output tsd_ctrl_t ctrl,
  output tsd_fixed_t fixed_seen,
  output logic word_applied
);

  logic [1:0] cnt_q, cnt_d;
  logic [15:0] hold_q, hold_d;
  tsd_synth_t down_q, down_d, up_q, up_d;
  logic [16:0] down_n_q, down_n_d;
  logic [14:0] up_n_q, up_n_d;
  tsd_ctrl_t ctrl_q, ctrl_d;
  tsd_fixed_t fix_q, fix_d;
  logic applied_q, applied_d;
  logic [23:0] word;
  logic word_done;
  logic hit_down_main;
  logic hit_down_ref;
  logic hit_up_main;
  logic hit_up_ref;
  logic hit_ctl1;
  logic hit_ctl2;
  logic hit_ctl3;

  function automatic logic [16:0] tsd_n(input logic [10:0] b, input logic [6:0] a, input int p);
    logic [16:0] prod;
    prod = 17'(b) * 17'(p);
    tsd_n = prod + 17'(a);
  endfunction

  // only the address bits steer a word; other fixed bits go unchecked
  function automatic logic tsd_match(input logic [23:0] w, input logic [3:0] hi, input logic [1:0] lo);
    tsd_match = (w[23:20] == hi) && (w[1:0] == lo);
  endfunction

  assign word = {hold_q, byte_data};
  // frame start wins, so a byte in its cycle is dropped
  assign word_done = byte_valid && !frame_start && (cnt_q == 2'(TSD_BYTES_PER_WORD - 1));

  assign hit_down_main = word_done && tsd_match(word, TSD_HI_DIV, TSD_LO_DOWN_MAIN);
  assign hit_down_ref = word_done && tsd_match(word, TSD_HI_REF, TSD_LO_DOWN_REF);
  assign hit_up_main = word_done && tsd_match(word, TSD_HI_DIV, TSD_LO_UP_MAIN);
  assign hit_up_ref = word_done && tsd_match(word, TSD_HI_REF, TSD_LO_UP_REF);
  assign hit_ctl1 = word_done && tsd_match(word, TSD_HI_CTL1, TSD_LO_CTL);
  assign hit_ctl2 = word_done && tsd_match(word, TSD_HI_CTL2, TSD_LO_CTL);
  assign hit_ctl3 = word_done && tsd_match(word, TSD_HI_CTL3, TSD_LO_CTL3);

  always_comb
  begin
    cnt_d = cnt_q;
    hold_d = hold_q;
    // a new start drops any partial group
    if (frame_start)
    begin
      cnt_d = 2'h0;
    end
    else if (byte_valid)
    begin
      if (word_done)
      begin
        cnt_d = 2'h0;
      end
      else
      begin
        hold_d = {hold_q[7:0], byte_data};
        cnt_d = cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 2'h0;
      hold_q <= 16'h0000;
    end
    else
    begin
      cnt_q <= cnt_d;
      hold_q <= hold_d;
    end
  end

  always_comb
  begin
    down_d = down_q;
    if (hit_down_main)
    begin
      down_d.a_count = word[TSD_A_LSB +: TSD_A_W];
      down_d.b_count = word[TSD_B_LSB +: TSD_B_W];
    end
    else if (hit_down_ref)
    begin
      down_d.r_count = word[TSD_DOWN_R_LSB +: TSD_DOWN_R_W];
    end
    // modulus is a constant, no register can change it
    down_n_d = tsd_n(down_d.b_count, down_d.a_count, TSD_DOWN_PRESCALE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      down_q <= '{b_count: TSD_B_RST, a_count: TSD_A_RST, r_count: TSD_R_RST};
      down_n_q <= 17'(TSD_DOWN_PRESCALE * TSD_B_RST + TSD_A_RST);
    end
    else
    begin
      down_q <= down_d;
      down_n_q <= down_n_d;
    end
  end

  always_comb
  begin
    up_d = up_q;
    if (hit_up_main)
    begin
      up_d.a_count = word[TSD_A_LSB +: TSD_A_W];
      up_d.b_count = word[TSD_B_LSB +: TSD_B_W];
    end
    else if (hit_up_ref)
    begin
      up_d.r_count = {2'h0, word[TSD_UP_R_LSB +: TSD_UP_R_W]};
    end
    // top bits drop; a legal up word never reaches them
    up_n_d = 15'(tsd_n(up_d.b_count, up_d.a_count, TSD_UP_PRESCALE));
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      up_q <= '{b_count: TSD_B_RST, a_count: TSD_A_RST, r_count: TSD_R_RST};
      up_n_q <= 15'(TSD_UP_PRESCALE * TSD_B_RST + TSD_A_RST);
    end
    else
    begin
      up_q <= up_d;
      up_n_q <= up_n_d;
    end
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (hit_ctl1)
    begin
      ctrl_d.wake = word[TSD_WAKE_BIT];
      ctrl_d.up_pump_current = word[TSD_UP_CP_LSB +: TSD_CP_W];
      ctrl_d.down_pump_current = word[TSD_DOWN_CP_LSB +: TSD_CP_W];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q <= '{wake: TSD_WAKE_RST, up_pump_current: TSD_CP_RST, down_pump_current: TSD_CP_RST};
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  always_comb
  begin
    fix_d = fix_q;
    // sticky until reset: nothing in the word stream clears them
    if (hit_ctl2)
    begin
      fix_d.ctl2_seen = 1'b1;
    end
    if (hit_ctl3)
    begin
      fix_d.ctl3_seen = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fix_q <= '0;
    end
    else
    begin
      fix_q <= fix_d;
    end
  end

  always_comb
  begin
    // an unknown pattern updates nothing and raises no pulse
    applied_d = hit_down_main || hit_down_ref || hit_up_main || hit_up_ref
      || hit_ctl1 || hit_ctl2 || hit_ctl3;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      applied_q <= 1'b0;
    end
    else
    begin
      applied_q <= applied_d;
    end
  end

  assign down_synth = down_q;
  assign up_synth = up_q;
  assign down_synth_n = down_n_q;
  assign up_synth_n = up_n_q;
  assign ctrl = ctrl_q;
  assign fixed_seen = fix_q;
  assign word_applied = applied_q;

endmodule

// File: verification/tsd_props.sv
`timescale 1ns/1ps
module tsd_props
  import tsd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic frame_start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire tsd_synth_t down_synth,
  input wire logic [16:0] down_synth_n,
  input wire tsd_ctrl_t ctrl,
  input wire logic word_applied
);
  logic [23:0] w_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // frame start drops its byte, so the shadow skips it too
  always_ff @(posedge clk)
    if (byte_valid && !frame_start) w_q <= {w_q[15:0], byte_data};
  n_sum_a: assert property (down_synth_n ==
    17'(TSD_DOWN_PRESCALE * down_synth.b_count + down_synth.a_count)) else $error("n sum");
  main_dec_a: assert property (word_applied && w_q[23:20] == 4'h0 && w_q[1:0] == 2'h1
    |-> {down_synth.b_count, down_synth.a_count} == w_q[19:2]) else $error("main decode");
  ref_dec_a: assert property (word_applied && w_q[23:16] == 8'h12 && w_q[1:0] == 2'h0
    |-> down_synth.r_count == w_q[13:2]) else $error("ref decode");
  ctl_dec_a: assert property (word_applied && w_q[23:20] == 4'h4 && w_q[1:0] == 2'h1
    |-> ctrl == {w_q[19], w_q[10:8], w_q[14:12]}) else $error("ctl decode");
  wake_rst_a: assert property ($rose(resetn) |-> !ctrl.wake) else $error("wake reset");
  syn_hold_a: assert property ($changed(down_synth) |-> word_applied) else $error("synth moved");
  ctl_hold_a: assert property ($changed(ctrl) |-> word_applied) else $error("ctrl moved");
  pulse_src_a: assert property (word_applied |-> $past(byte_valid) && !$past(frame_start))
    else $error("stray pulse");
  cover property (word_applied && w_q[1:0] == 2'h0);
  cover property (word_applied && w_q[23:20] == 4'h4);
  cover property (frame_start ##1 byte_valid ##1 byte_valid ##1 !byte_valid);
endmodule
bind tsd_regs tsd_props props_u (.clk(clk), .resetn(resetn), .frame_start(frame_start), .byte_valid(byte_valid),
  .byte_data(byte_data), .down_synth(down_synth), .down_synth_n(down_synth_n), .ctrl(ctrl), .word_applied(word_applied));

// File: verification/tsd_host.sv
`timescale 1ns/1ps
module tsd_host (
  input wire logic clk,
  output logic frame_start,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  initial {frame_start, byte_valid, byte_data} = '0;
  // fewer than three bytes leaves a partial group behind
  task automatic send(input logic [23:0] w, input int n);
    @(posedge clk);
    frame_start <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      frame_start <= 1'b0;
      byte_valid <= 1'b1;
      byte_data <= w[23 - 8 * i -: 8];
    end
    @(posedge clk);
    frame_start <= 1'b0;
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
  endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb
  import tsd_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic frame_start, byte_valid, word_applied;
  logic [7:0] byte_data;
  tsd_synth_t down_synth, d, up_synth, u;
  tsd_ctrl_t ctrl, c;
  tsd_fixed_t fixed_seen, f;
  logic [16:0] down_synth_n;
  logic [14:0] up_synth_n;
  logic [100:0] q[$];
  logic [31:0] s = 32'h0000E59F, r;
  logic [23:0] w;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  tsd_regs dut_u (.clk(clk), .resetn(resetn), .frame_start(frame_start), .byte_valid(byte_valid),
    .byte_data(byte_data), .down_synth(down_synth), .up_synth(up_synth), .down_synth_n(down_synth_n),
    .up_synth_n(up_synth_n), .ctrl(ctrl), .fixed_seen(fixed_seen), .word_applied(word_applied));
  tsd_host host_u (.clk(clk), .frame_start(frame_start), .byte_valid(byte_valid), .byte_data(byte_data));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [100:0] exp_v();
    return {d, c, 17'(TSD_DOWN_PRESCALE * d.b_count + d.a_count),
      u, 15'(TSD_UP_PRESCALE * u.b_count + u.a_count), f};
  endfunction
  function automatic logic [100:0] got_v();
    return {down_synth, ctrl, down_synth_n, up_synth, up_synth_n, fixed_seen};
  endfunction
  task automatic chk(input logic [100:0] got, input logic [100:0] e);
    samples_checked++;
    if (got !== e)
    begin
      error_cnt++;
      $display("ERROR regs exp %h got %h", e, got);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d pending %0d", error_cnt, samples_checked, q.size());
    if (error_cnt == 0 && samples_checked > 0 && q.size() == 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      error_cnt++;
      $display("ERROR timeout exp cycles below %0d got %0d", 1000, cyc);
      end_sim();
    end
  end
  always @(negedge clk)
    if (word_applied !== 1'b0) chk(got_v(), q.size() ? q.pop_front() : '1);
  initial
  begin
    d = {TSD_B_RST, TSD_A_RST, TSD_R_RST};
    u = {TSD_B_RST, TSD_A_RST, TSD_R_RST};
    c = {TSD_WAKE_RST, TSD_CP_RST, TSD_CP_RST};
    f = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk(got_v(), exp_v());
    for (int k = 0; k < 30; k++)
    begin
      r = rnd();
      case (k % 6)
        0, 4: w = {4'h0, r[10:0] | 11'h040, 1'b0, r[16:11], 2'b01};
        1: w = {8'h12, 2'b00, r[28:17] | 12'h002, 2'b00};
        2: w = {4'h4, r[31], 4'h0, 3'(r[20:18] % 7 + 1), 1'b0, 3'(r[23:21] % 7 + 1), 8'h81};
        3: w = {4'h0, r[10:0] | 11'h040, 3'b000, r[14:11], 2'b11};
        default: w = {4'h7, r[19:0]};
      endcase
      host_u.send(w, k % 6 == 4 ? 2 : 3);
      if (k % 6 == 0) {d.b_count, d.a_count} = w[19:2];
      if (k % 6 == 1) d.r_count = w[13:2];
      if (k % 6 == 2) c = {w[19], w[10:8], w[14:12]};
      if (k % 6 == 3) {u.b_count, u.a_count} = w[19:2];
      if (k % 6 < 4) q.push_back(exp_v());
    end
    r = rnd();
    w = {8'h12, 4'h0, r[9:0] | 10'h002, 2'b10};
    host_u.send(w, 3);
    u.r_count = {2'h0, w[11:2]};
    q.push_back(exp_v());
    host_u.send(24'h580009, 3);
    f.ctl2_seen = 1'b1;
    q.push_back(exp_v());
    host_u.send(24'h610247, 3);
    f.ctl3_seen = 1'b1;
    q.push_back(exp_v());
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
